/* aml_pkg.sv */
// Shared types and constants for the Layer 4 ACL match, action and count block.
// Assumes a 200 MHz core clock and one instance per switch port.
package aml_pkg;
  localparam int NENT = 16;
  localparam int FWD_W = 5;
  localparam int CNT_W = 11;
  localparam int CLK_NS = 5;
  localparam int US_NS = 1000;
  localparam int US_PER_MS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_NS;
  localparam logic [7:0] US_DIV_MAX = 8'(CYC_PER_US - 1);
  localparam logic [9:0] MS_DIV_MAX = 10'(US_PER_MS - 1);
  localparam logic [7:0] PROTO_TCP = 8'h06;
  localparam logic [7:0] PROTO_UDP = 8'h11;
  localparam logic [1:0] MODE_L2 = 2'h0 + 2'h1;
  localparam logic [1:0] MODE_L4 = 2'h3;
  localparam logic [1:0] SUB_PROTO = 2'h0;
  localparam logic [1:0] SUB_TCP = 2'h1;
  localparam logic [1:0] SUB_UDP = 2'h2;
  localparam logic [1:0] SUB_SEQ = 2'h3;
  // Byte offsets; table word = entry * 16 + word * 4
  localparam logic [8:0] OFF_TBL_END = 9'h100;
  localparam logic [8:0] OFF_PSTAT = 9'h100;
  localparam logic [8:0] OFF_PMASK = 9'h104;
  localparam logic [8:0] OFF_GSTAT = 9'h108;
  localparam logic [8:0] OFF_GMASK = 9'h10C;
  localparam logic [1:0] WRD_MATCH = 2'h0;
  localparam logic [1:0] WRD_BOUND = 2'h1;
  localparam logic [1:0] WRD_ACT = 2'h2;
  localparam logic [1:0] WRD_CNT = 2'h3;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] flag;
    logic [7:0] tcp_flag_ignore_bits;
    logic [7:0] proto;
    logic [1:0] pc;
    logic pol;
    logic dir;
    logic [1:0] sub;
    logic [1:0] mode;
  } aml_match_t;

  // Flag enable sits above the forwarding map: the match word has no spare bit for it
  typedef struct packed {
    logic flag_match_enable;
    logic [FWD_W-1:0] fwd;
    logic ca;
    logic tu;
    logic [1:0] mm;
    logic [2:0] rp;
    logic remark_enable;
    logic [2:0] p;
    logic [1:0] pm;
  } aml_act_t;

  localparam int ACT_W = $bits(aml_act_t);

  typedef struct packed {
    aml_act_t act;
    logic [31:0] bounds;
    aml_match_t m;
  } aml_entry_t;

  typedef struct packed {
    logic [FWD_W-1:0] lkp_map;
    logic [2:0] qos;
    logic [NENT-1:0] l2_hit;
    logic [31:0] seq;
    logic [7:0] flags;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [7:0] proto;
  } aml_pkt_t;

  typedef struct packed {
    logic [FWD_W-1:0] map;
    logic [2:0] prio;
    logic remark;
    logic [2:0] pcp;
    logic [NENT-1:0] hits;
  } aml_res_t;

  typedef struct packed {
    aml_entry_t [NENT-1:0] tbl;
    logic [NENT-1:0][CNT_W-1:0] cnt;
    logic [NENT-1:0] armed;
    logic [7:0] us_div;
    logic [9:0] ms_div;
    logic [NENT-1:0] pstat;
    logic pmask;
    logic gmask;
    logic [31:0] rdata;
    logic ack;
    logic res_valid;
    aml_res_t res;
  } aml_state_t;
endpackage : aml_pkg

/* aml_top.sv */
// Layer 4 ACL evaluator for one switch port: rule table, actions, count mode.
// Assumes packet header fields arrive already parsed, one packet per pkt_valid.
module aml_top import aml_pkg::*; #(
  parameter logic [4:0] PORT_ID = 5'h00
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pkt_valid,
  input wire aml_pkg::aml_pkt_t pkt,
  output logic res_valid,
  output aml_pkg::aml_res_t res,
  output logic port_irq,
  output logic irq
);
  import aml_pkg::*;

  aml_state_t s_reg;
  aml_state_t s_next;
  logic us_tick;
  logic ms_tick;
  logic req;
  logic wr_go;
  logic [NENT-1:0] fhit;
  logic [NENT-1:0] cm_vec;
  logic [NENT-1:0] ev;
  logic [NENT-1:0] clr;
  logic have_sel;
  aml_act_t sel;
  logic [3:0] ent;
  logic [1:0] wrd;

  function automatic logic is_count(aml_match_t m);
    return m.mode == MODE_L2 && m.sub == SUB_PROTO;
  endfunction : is_count

  function automatic logic [CNT_W-1:0] cval(aml_act_t a);
    return {a.pm, a.p, a.remark_enable, a.rp, a.mm};
  endfunction : cval

  function automatic logic l4_hit(aml_entry_t e, aml_pkt_t p);
    logic [15:0] port;
    logic [15:0] hi;
    logic [15:0] lo;
    logic tcp;
    logic udp;
    logic eq;
    logic pok;
    logic fok;
    port = e.m.dir ? p.sport : p.dport;
    hi = e.bounds[31:16];
    lo = e.bounds[15:0];
    tcp = p.proto == PROTO_TCP;
    udp = p.proto == PROTO_UDP;
    fok = !e.act.flag_match_enable || (tcp && (((p.flags ^ e.m.flag) & ~e.m.tcp_flag_ignore_bits) == 8'h00));
    case (e.m.pc)
      2'h1: eq = port == hi || port == lo;
      2'h2: eq = port >= lo && port <= hi;
      2'h3: eq = port < lo || port > hi;
      default: eq = 1'b0;
    endcase
    pok = (e.m.pc == 2'h0) || (e.m.pol ? eq : !eq);
    case (e.m.sub)
      SUB_PROTO: begin
        eq = p.proto == e.m.proto;
        l4_hit = e.m.pol ? eq : !eq;
      end
      SUB_TCP: l4_hit = tcp && pok && fok;
      SUB_UDP: l4_hit = udp && pok;
      SUB_SEQ: begin
        eq = p.seq == e.bounds;
        l4_hit = tcp && (e.m.pol ? eq : !eq) && fok;
      end
      default: l4_hit = 1'b0;
    endcase
  endfunction : l4_hit

  function automatic logic [31:0] rd_word(aml_state_t st, logic [8:0] a, logic pirq);
    logic [31:0] w;
    w = RST_WORD;
    if (a < OFF_TBL_END) begin
      case (a[3:2])
        WRD_MATCH: w = st.tbl[a[7:4]].m;
        WRD_BOUND: w = st.tbl[a[7:4]].bounds;
        WRD_ACT: w[ACT_W-1:0] = st.tbl[a[7:4]].act;
        default: w[CNT_W:0] = {st.armed[a[7:4]], st.cnt[a[7:4]]};
      endcase
    end else begin
      case ({a[8:2], 2'h0})
        OFF_PSTAT: w[NENT-1:0] = st.pstat;
        OFF_PMASK: w[0] = st.pmask;
        OFF_GSTAT: w[PORT_ID] = pirq;
        OFF_GMASK: w[PORT_ID] = st.gmask;
        default: w = RST_WORD;
      endcase
    end
    return w;
  endfunction : rd_word

  assign req = avs_read | avs_write;
  // One wait state: data is captured on the first edge and handed over on the second
  assign avs_waitrequest = req & ~s_reg.ack;
  assign wr_go = avs_write & s_reg.ack;
  assign avs_readdata = s_reg.rdata;
  assign res_valid = s_reg.res_valid;
  assign res = s_reg.res;
  assign port_irq = (|s_reg.pstat) & s_reg.pmask;
  assign irq = port_irq & s_reg.gmask;
  assign ent = avs_address[7:4];
  assign wrd = avs_address[3:2];
  assign us_tick = s_reg.us_div == US_DIV_MAX;
  assign ms_tick = us_tick && s_reg.ms_div == MS_DIV_MAX;

  always_comb begin
    s_next = s_reg;
    ev = '0;
    clr = '0;
    fhit = '0;
    cm_vec = '0;
    have_sel = 1'b0;
    sel = '0;

    s_next.us_div = us_tick ? 8'h00 : s_reg.us_div + 8'h01;
    if (us_tick) begin
      s_next.ms_div = ms_tick ? 10'h000 : s_reg.ms_div + 10'h001;
    end

    for (int i = 0; i < NENT; i++) begin
      cm_vec[i] = is_count(s_reg.tbl[i].m);
      if (cm_vec[i]) begin
        if (s_reg.tbl[i].act.ca) begin
          if (pkt_valid && pkt.l2_hit[i]) begin
            if (s_reg.cnt[i] + 11'h001 == cval(s_reg.tbl[i].act)) begin
              ev[i] = 1'b1;
              s_next.cnt[i] = '0;
            end else begin
              s_next.cnt[i] = s_reg.cnt[i] + 11'h001;
            end
          end
          s_next.armed[i] = 1'b0;
        end else if (pkt_valid && pkt.l2_hit[i]) begin
          s_next.cnt[i] = cval(s_reg.tbl[i].act);
          s_next.armed[i] = 1'b1;
        end else if (s_reg.armed[i] && (s_reg.tbl[i].act.tu ? ms_tick : us_tick)) begin
          // Expiry lands on the tick that would take the count below one
          if (s_reg.cnt[i] <= 11'h001) begin
            ev[i] = 1'b1;
            s_next.armed[i] = 1'b0;
            s_next.cnt[i] = '0;
          end else begin
            s_next.cnt[i] = s_reg.cnt[i] - 11'h001;
          end
        end
      end else begin
        s_next.cnt[i] = '0;
        s_next.armed[i] = 1'b0;
        fhit[i] = s_reg.tbl[i].m.mode == MODE_L4 && l4_hit(s_reg.tbl[i], pkt);
      end
    end

    // Lowest numbered hit owns the action; entries do not chain
    for (int i = NENT - 1; i >= 0; i--) begin
      if (fhit[i]) begin
        have_sel = 1'b1;
        sel = s_reg.tbl[i].act;
      end
    end

    s_next.res_valid = pkt_valid;
    if (pkt_valid) begin
      s_next.res.hits = fhit;
      s_next.res.prio = pkt.qos;
      s_next.res.remark = 1'b0;
      s_next.res.pcp = 3'h0;
      s_next.res.map = pkt.lkp_map;
      if (have_sel) begin
        case (sel.pm)
          2'h1: s_next.res.prio = (sel.p > pkt.qos) ? sel.p : pkt.qos;
          2'h2: s_next.res.prio = (sel.p < pkt.qos) ? sel.p : pkt.qos;
          2'h3: s_next.res.prio = sel.p;
          default: s_next.res.prio = pkt.qos;
        endcase
        s_next.res.remark = sel.remark_enable;
        s_next.res.pcp = sel.remark_enable ? sel.rp : 3'h0;
        case (sel.mm)
          2'h1: s_next.res.map = pkt.lkp_map | sel.fwd;
          2'h2: s_next.res.map = pkt.lkp_map & sel.fwd;
          2'h3: s_next.res.map = sel.fwd;
          default: s_next.res.map = pkt.lkp_map;
        endcase
      end
    end

    s_next.ack = req & ~s_reg.ack;
    if (req && !s_reg.ack) begin
      s_next.rdata = rd_word(s_reg, avs_address, port_irq);
    end
    if (wr_go) begin
      if (avs_address < OFF_TBL_END) begin
        case (wrd)
          WRD_MATCH: s_next.tbl[ent].m = avs_writedata;
          WRD_BOUND: s_next.tbl[ent].bounds = avs_writedata;
          WRD_ACT: s_next.tbl[ent].act = avs_writedata[ACT_W-1:0];
          default: s_next.tbl[ent].act = s_reg.tbl[ent].act;
        endcase
      end else begin
        case ({avs_address[8:2], 2'h0})
          OFF_PSTAT: clr = avs_writedata[NENT-1:0];
          OFF_PMASK: s_next.pmask = avs_writedata[0];
          OFF_GMASK: s_next.gmask = avs_writedata[PORT_ID];
          default: s_next.pmask = s_reg.pmask;
        endcase
      end
    end
    // A new event in the clearing cycle survives the clear
    s_next.pstat = (s_reg.pstat & ~clr) | (ev & cm_vec);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_filter_no_irq: assert property (
    ((s_reg.pstat & ~$past(s_reg.pstat) & ~$past(cm_vec)) == '0)
  ) else $error("status bit set by a non-count entry");

  chk_set_wins: assert property (
    (wr_go && clr[0] && ev[0]) |=> s_reg.pstat[0]
  ) else $error("event lost under status clear");

  chk_global_gate: assert property (
    (s_reg.pstat[0] && s_reg.pmask && s_reg.gmask) |-> irq
  ) else $error("interrupt not raised through both masks");

  chk_prio_always: assert property (
    (pkt_valid && have_sel && sel.pm == 2'h3) |=> (res_valid && res.prio == $past(sel.p))
  ) else $error("always-apply priority not taken");

  chk_map_or: assert property (
    (pkt_valid && have_sel && sel.mm == 2'h1) |=> res.map == ($past(pkt.lkp_map) | $past(sel.fwd))
  ) else $error("forwarding maps not merged by OR");

  chk_remark_pcp: assert property (
    (pkt_valid && have_sel && sel.remark_enable) |=> (res.remark && res.pcp == $past(sel.rp))
  ) else $error("PCP remark not applied");

  chk_proto_pol: assert property (
    (pkt_valid && s_reg.tbl[0].m.mode == MODE_L4 && s_reg.tbl[0].m.sub == SUB_PROTO
      && pkt.proto == s_reg.tbl[0].m.proto) |=> res.hits[0] == $past(s_reg.tbl[0].m.pol)
  ) else $error("protocol compare ignores polarity");

  chk_reload_gap: assert property (
    (cm_vec[0] && !s_reg.tbl[0].act.ca && pkt_valid && pkt.l2_hit[0])
      |=> (s_reg.armed[0] && s_reg.cnt[0] == $past(cval(s_reg.tbl[0].act)))
  ) else $error("down-counter not reloaded on match");

  chk_expiry_flag: assert property (
    ($fell(s_reg.armed[0]) && cm_vec[0] && $past(cm_vec[0])) |-> s_reg.pstat[0]
  ) else $error("expiry did not flag status");

  chk_terminal: assert property (
    (cm_vec[0] && s_reg.tbl[0].act.ca && pkt_valid && pkt.l2_hit[0]
      && s_reg.cnt[0] + 11'h001 == cval(s_reg.tbl[0].act)) |=> (s_reg.cnt[0] == '0 && s_reg.pstat[0])
  ) else $error("terminal count not handled");

  chk_bus_wait: assert property (
    (req && avs_waitrequest) |=> !avs_waitrequest
  ) else $error("waitrequest not released after one cycle");

  cov_expire: cover property ($fell(s_reg.armed[0]) && s_reg.pstat[0]);
  cov_terminal: cover property (ev[0] && s_reg.tbl[0].act.ca);
  cov_filter_hit: cover property (pkt_valid && have_sel && sel.mm == 2'h3);
  cov_irq: cover property ($rose(irq));
endmodule : aml_top

/* aml_pipe_model.sv */
// Far-side model: the ingress lookup pipeline that feeds parsed packets.
// Assumes calls start just after a rising edge; the result stands one cycle.
module aml_pipe_model import aml_pkg::*; (
  input wire logic mclk,
  output logic pkt_valid,
  output aml_pkg::aml_pkt_t pkt,
  input wire logic res_valid,
  input wire aml_pkg::aml_res_t res
);
  initial begin
    pkt_valid = 1'b0;
    pkt = '0;
  end

  task automatic send(input aml_pkt_t p, output logic v, output aml_res_t r);
    pkt_valid <= 1'b1;
    pkt <= p;
    @(posedge mclk);
    pkt_valid <= 1'b0;
    // Released fields must not look valid by keeping their old value
    pkt <= ~p;
    @(negedge mclk);
    v = res_valid;
    r = res;
    @(posedge mclk);
  endtask : send
endmodule : aml_pipe_model

/* acl_layer4_match_action_count_test.sv */
// Self-checking bench: random Layer 4 rules and packets, then both count algorithms.
// Assumes one port instance; the bench is the register master, the model sends packets.
module acl_layer4_match_action_count_test;
  timeunit 1ns;
  timeprecision 1ps;
  import aml_pkg::*;
  localparam logic [4:0] PID = 5'h03;
  logic mclk, reset, avs_read, avs_write, avs_waitrequest, pkt_valid, res_valid, port_irq, irq, v;
  logic [8:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, w0, b, w2;
  aml_pkt_t pkt, p;
  aml_res_t res, r;
  int fails, samples_checked, ent, n;

  aml_top #(.PORT_ID(PID)) uut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pkt_valid(pkt_valid), .pkt(pkt), .res_valid(res_valid), .res(res),
    .port_irq(port_irq), .irq(irq));
  aml_pipe_model u_pipe (.mclk(mclk), .pkt_valid(pkt_valid), .pkt(pkt), .res_valid(res_valid), .res(res));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) begin
        q = avs_readdata;
        break;
      end
      if (i == 19) begin
        fails++;
        summarize();
      end
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // One idle edge, so the next call never re-raises a strobe in this time step
    @(posedge mclk);
  endtask : bus

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr

  task automatic rc(input logic [8:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask : rc

  function automatic logic [8:0] ad(input int e, input logic [1:0] w);
    return {1'b0, 4'(e), w, 2'h0};
  endfunction : ad

  function automatic logic hit_of(input logic [31:0] w, input logic [31:0] bd, input logic fe, input aml_pkt_t q);
    logic [15:0] pt;
    logic c;
    pt = w[4] ? q.sport : q.dport;
    case (w[7:6])
      2'h1: c = (pt == bd[31:16]) || (pt == bd[15:0]);
      2'h2: c = (pt >= bd[15:0]) && (pt <= bd[31:16]);
      default: c = (pt < bd[15:0]) || (pt > bd[31:16]);
    endcase
    if (w[3:2] == SUB_PROTO) c = (q.proto == w[15:8]);
    if (w[3:2] == SUB_SEQ) c = (q.seq == bd);
    c = (c == w[5]);
    if (w[2] && fe && ((q.flags ^ w[31:24]) & ~w[23:16]) != 8'h00) c = 1'b0;
    return c;
  endfunction : hit_of

  function automatic aml_res_t exp_res(input logic h, input int e, input logic [31:0] a, input aml_pkt_t q);
    aml_res_t x;
    x = '0;
    x.prio = q.qos;
    x.map = q.lkp_map;
    if (h) begin
      x.hits[e] = 1'b1;
      if (a[1:0] == 2'h3 || (a[1:0] == 2'h1 && a[4:2] > q.qos) || (a[1:0] == 2'h2 && a[4:2] < q.qos)) x.prio = a[4:2];
      x.remark = a[5];
      x.pcp = a[5] ? a[8:6] : 3'h0;
      case (a[10:9])
        2'h1: x.map = q.lkp_map | a[17:13];
        2'h2: x.map = q.lkp_map & a[17:13];
        2'h3: x.map = a[17:13];
        default: ;
      endcase
    end
    return x;
  endfunction : exp_res

  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    void'($urandom(32'hcec4_f1c5));
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rc(ad(0, WRD_MATCH), RST_WORD);
    wr(ad(9, WRD_CNT), 32'hffff_ffff);
    rc(ad(9, WRD_CNT), 32'h0000_0000);
    rc(9'h1F0, 32'h0000_0000);
    for (int k = 0; k < 300; k++) begin
      ent = $urandom % NENT;
      b[15:0] = 16'($urandom);
      b[31:16] = b[15:0] + 16'($urandom % 64);
      w0 = $urandom;
      w0[1:0] = MODE_L4;
      w0[7:6] = 2'(1 + $urandom % 3);
      w2 = $urandom;
      p = aml_pkt_t'(104'({$urandom, $urandom, $urandom, $urandom}));
      case ($urandom % 4)
        0: p.dport = b[15:0];
        1: p.dport = b[31:16];
        2: p.dport = b[31:16] + 16'h0001;
        default: p.dport = b[15:0] + 16'($urandom % 80);
      endcase
      if (w0[4]) p.sport = p.dport;
      if ($urandom % 2) begin
        p.seq = b;
        p.proto = w0[15:8];
        p.flags = w0[31:24];
      end
      if (w0[3:2] == SUB_UDP) p.proto = PROTO_UDP;
      else if (w0[2]) p.proto = PROTO_TCP;
      wr(ad(ent, WRD_MATCH), w0);
      wr(ad(ent, WRD_BOUND), b);
      wr(ad(ent, WRD_ACT), w2);
      u_pipe.send(p, v, r);
      chk({31'h0, v}, 32'h1);
      chk({4'h0, r}, {4'h0, exp_res(hit_of(w0, b, w2[18], p), ent, w2, p)});
      wr(ad(ent, WRD_MATCH), 32'h0000_0000);
    end
    wr(OFF_PMASK, 32'h1);
    wr(OFF_GMASK, 32'h1 << PID);
    rc(OFF_PSTAT, 32'h0000_0000);
    // Algorithm 1, terminal count 3 held in the map mode bits
    wr(ad(2, WRD_ACT), 32'h0000_1600);
    wr(ad(2, WRD_MATCH), 32'h0000_0001);
    p = '0;
    p.l2_hit[2] = 1'b1;
    repeat (2) u_pipe.send(p, v, r);
    chk({16'h0, r.hits}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    u_pipe.send(p, v, r);
    @(negedge mclk);
    chk({30'h0, port_irq, irq}, 32'h3);
    rc(OFF_PSTAT, 32'h0000_0004);
    rc(OFF_GSTAT, 32'h1 << PID);
    wr(OFF_GMASK, 32'h0000_0000);
    chk({30'h0, port_irq, irq}, 32'h2);
    wr(OFF_PMASK, 32'h0000_0000);
    chk({31'h0, port_irq}, 32'h0);
    wr(OFF_PSTAT, 32'h0000_0004);
    rc(OFF_PSTAT, 32'h0000_0000);
    wr(ad(2, WRD_MATCH), 32'h0000_0000);
    wr(OFF_PMASK, 32'h1);
    // Algorithm 0, two microsecond window; refreshed faster than it can expire
    wr(ad(0, WRD_ACT), 32'h0000_0400);
    wr(ad(0, WRD_MATCH), 32'h0000_0001);
    p = '0;
    p.l2_hit[0] = 1'b1;
    u_pipe.send(p, v, r);
    repeat (8) begin
      repeat (150) @(posedge mclk);
      u_pipe.send(p, v, r);
    end
    chk({31'h0, port_irq}, 32'h0);
    n = 0;
    while (port_irq !== 1'b1 && n < 700) begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, n >= 190 && n <= 410}, 32'h1);
    rc(OFF_PSTAT, 32'h0000_0001);
    summarize();
  end
endmodule : acl_layer4_match_action_count_test
